// File: common/pin_change_pkg.sv
// package for the pin change interrupt unit: register map, field layout, reset values
// assumes an 8-bit register port with a 4-bit word address and one system clock
package pin_change_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 8;
   localparam int NUM_PORTS = 3;
   localparam int PORT_W    = 8;

   // ==========================================================
   // register map: three registers per port, then the shared ones
   localparam logic [3:0] OFF_PORT_BASE  = 4'h0;
   localparam logic [3:0] PORT_STRIDE    = 4'h3;
   localparam logic [3:0] KIND_RISE      = 4'h0;
   localparam logic [3:0] KIND_FALL      = 4'h1;
   localparam logic [3:0] KIND_FLAGS     = 4'h2;
   localparam logic [3:0] OFF_CONTROL    = 4'h9;
   localparam logic [3:0] OFF_SUMMARY    = 4'ha;
   localparam logic [3:0] OFF_EVT_STATUS = 4'hb;
   localparam logic [3:0] OFF_EVT_MASK   = 4'hc;

   // ==========================================================
   // implemented bits of each port (index 0 = port a)
   localparam logic [7:0] PORTA_IMPL = 8'h3f;
   localparam logic [7:0] PORTB_IMPL = 8'hf0;
   localparam logic [7:0] PORTC_IMPL = 8'hff;
   localparam logic [NUM_PORTS-1:0][7:0] PORT_IMPL = {PORTC_IMPL, PORTB_IMPL, PORTA_IMPL};

   // ==========================================================
   // field positions
   localparam int CTRL_MASTER_EN_BIT = 0;
   localparam int SUMMARY_FLAG_BIT   = 0;

   // ==========================================================
   // reset values
   localparam logic [7:0] ENABLE_RESET     = 8'h00;
   localparam logic [7:0] FLAGS_RESET      = 8'h00;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] EVT_STATUS_RESET = 8'h00;
   localparam logic [7:0] EVT_MASK_RESET   = 8'h00;
   localparam logic [7:0] RDATA_RESET      = 8'h00;

endpackage

// File: design/pin_edge_detect.sv
// per-port pin synchroniser and rising/falling edge detector
// assumes pins are sampled on clk_sys_in; enables come from the register block
`timescale 1ns/1ns
module pin_edge_detect #(
   parameter int         WIDTH     = 8,
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   input  wire logic             clk_sys_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] pins_in,
   input  wire logic [WIDTH-1:0] rise_en_in,
   input  wire logic [WIDTH-1:0] fall_en_in,
   output logic      [WIDTH-1:0] set_out
);

   // ==========================================================
   // synchroniser and history
   logic [WIDTH-1:0] sync1_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] rise_hit;
   logic [WIDTH-1:0] fall_hit;

   // three flops per pin (sync1, sync2, prev); sync1 is read by sync2 only, so edges come from sync2 vs prev
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else begin
         sync1_reg <= pins_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // ==========================================================
   // edge qualification
   // both detectors run side by side, so a pin may watch both polarities
   always_comb begin
      rise_hit = sync2_reg & ~prev_reg & rise_en_in;
      fall_hit = ~sync2_reg & prev_reg & fall_en_in;
      set_out  = (rise_hit | fall_hit) & IMPL_MASK[WIDTH-1:0];
   end

endmodule

// File: design/pin_change_unit.sv
// pin change interrupt unit: edge enables, change flags, summary flag, irq and wake
// assumes a simple register port (read data one cycle later) and pins synchronous-safe
//
// Notes on behaviour
// - per-pin rising detector gated by rise enable
// - per-pin falling detector gated by fall enable
// - both enables set detect either polarity
// - enabled edge sets flag; request needs master
// - master off: flags still set, no request
// - summary flag is OR of flags, read-only
// - writing zero to a flag clears it
// - edge during clearing write leaves flag set
// - change event wakes sleep only with master
// - port a rise enables bits 5-0, 7-6 zero
// - port a fall enables bits 5-0, 7-6 zero
// - port a flags bits 5-0, 7-6 zero
// - port b uses bits 7-4 only
// - port c uses all eight bits
`timescale 1ns/1ns
module pin_change_unit (
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   // register port
   input  wire logic [3:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // external pins
   input  wire logic [7:0]  porta_pins_in,
   input  wire logic [7:0]  portb_pins_in,
   input  wire logic [7:0]  portc_pins_in,
   // power state and requests
   input  wire logic        sleep_in,
   output logic             irq_out,
   output logic             summary_flag_out,
   output logic             wake_out
);

   localparam int NP = pin_change_pkg::NUM_PORTS;

   // ==========================================================
   // address map, word index on addr_in
   //   0x0 .. 0x2  port a: rise enable, fall enable, change flags (bits 5-0)
   //   0x3 .. 0x5  port b: the same three registers, bits 7-4 only
   //   0x6 .. 0x8  port c: the same three registers, all eight bits
   //   0x9         control: bit 0 is the master change enable
   //   0xa         summary: bit 0 is the or of every flag, read-only
   //   0xb         event status: one sticky bit per port, write one to clear
   //   0xc         event mask: one bit per port, gates irq_out only
   //   0xd .. 0xf  unmapped: reads give zero, writes are dropped

   // ==========================================================
   // helper functions
   // byte address of one of the three registers belonging to a port
   // ports sit three words apart, so port p owns words 3p to 3p+2
   function automatic logic [3:0] port_addr(input int port, input logic [3:0] kind);
      logic [7:0] full;
      full = 8'(pin_change_pkg::OFF_PORT_BASE) + 8'(pin_change_pkg::PORT_STRIDE) * 8'(port)
             + 8'(kind);
      return full[3:0];
   endfunction

   // one write-to-register decision, used by every writable register
   function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
      return a == target;
   endfunction

   // next value of a hardware-set flag byte: write replaces, then sets are merged
   // the or after the write makes a coinciding edge win over a clearing write
   function automatic logic [7:0] flag_step(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic       wr,
                                            input logic [7:0] wdata,
                                            input logic [7:0] impl);
      logic [7:0] base;
      base = wr ? wdata : cur;
      return (base | set) & impl;
   endfunction

   // ==========================================================
   // state
   // one entry per port in each array, index 0 is port a
   logic [7:0]    rise_en_reg  [NP];
   logic [7:0]    fall_en_reg  [NP];
   logic [7:0]    flags_reg    [NP];
   logic [7:0]    flags_next   [NP];
   logic [7:0]    set_pulse    [NP];
   logic [7:0]    pins         [NP];
   logic [7:0]    control_reg;
   logic [NP-1:0] evt_status_reg;
   logic [NP-1:0] evt_status_next;
   logic [NP-1:0] evt_mask_reg;
   logic [NP-1:0] evt_pulse;
   logic [7:0]    rdata_reg;
   logic [7:0]    rdata_next;
   logic          irq_reg;
   logic          wake_reg;
   logic          summary;
   logic          master_en;
   logic [7:0]    control_next;
   logic [NP-1:0] wr_rise;
   logic [NP-1:0] wr_fall;
   logic [NP-1:0] wr_flags;
   logic          wr_control;
   logic          wr_evt_status;
   logic          wr_evt_mask;

   assign pins[0] = porta_pins_in;
   assign pins[1] = portb_pins_in;
   assign pins[2] = portc_pins_in;

   assign master_en = control_reg[pin_change_pkg::CTRL_MASTER_EN_BIT];

   // ==========================================================
   // edge detection, one detector block per port
   // detection runs whatever the master enable says; it only gates requests
   // the synchroniser costs latency: a pin change reaches the flags three
   // edges later, and a pulse shorter than one clock may be missed
   for (genvar p = 0; p < NP; p++) begin : g_port
      pin_edge_detect #(
         .WIDTH     (8),
         .IMPL_MASK (pin_change_pkg::PORT_IMPL[p])
      ) u_detect (
         .clk_sys_in (clk_sys_in),
         .nrst_in    (nrst_in),
         .pins_in    (pins[p]),
         .rise_en_in (rise_en_reg[p]),
         .fall_en_in (fall_en_reg[p]),
         .set_out    (set_pulse[p])
      );
   end

   // ==========================================================
   // write decode, shared by every register process so each address is
   // compared in one place; a strobe that matches no register changes nothing
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         wr_rise[p]  = wr_in && hit(addr_in, port_addr(p, pin_change_pkg::KIND_RISE));
         wr_fall[p]  = wr_in && hit(addr_in, port_addr(p, pin_change_pkg::KIND_FALL));
         wr_flags[p] = wr_in && hit(addr_in, port_addr(p, pin_change_pkg::KIND_FLAGS));
      end
      wr_control    = wr_in && hit(addr_in, pin_change_pkg::OFF_CONTROL);
      wr_evt_status = wr_in && hit(addr_in, pin_change_pkg::OFF_EVT_STATUS);
      wr_evt_mask   = wr_in && hit(addr_in, pin_change_pkg::OFF_EVT_MASK);
   end

   // ==========================================================
   // edge enable registers
   // unimplemented bits are masked on write so they always read zero
   // enabling a pin that is already high does not flag it: only a later edge
   // does, since detection compares two successive samples
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NP; p++) begin
            rise_en_reg[p] <= pin_change_pkg::ENABLE_RESET;
            fall_en_reg[p] <= pin_change_pkg::ENABLE_RESET;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            if (wr_rise[p]) begin
               rise_en_reg[p] <= wdata_in & pin_change_pkg::PORT_IMPL[p];
            end
            if (wr_fall[p]) begin
               fall_en_reg[p] <= wdata_in & pin_change_pkg::PORT_IMPL[p];
            end
         end
      end
   end

   // ==========================================================
   // change flag next values
   // a write of zero clears; a detected edge in the same cycle still sets the bit
   // software should write back the byte it read with the seen bits removed;
   // a blind zero can drop an edge caught between its read and its write
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         flags_next[p] = flag_step(flags_reg[p],
                                   set_pulse[p],
                                   wr_flags[p],
                                   wdata_in,
                                   pin_change_pkg::PORT_IMPL[p]);
      end
   end

   // change flag registers
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NP; p++) begin
            flags_reg[p] <= pin_change_pkg::FLAGS_RESET;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            flags_reg[p] <= flags_next[p];
         end
      end
   end

   // ==========================================================
   // summary flag: or of every port flag, taken from the registered flags
   always_comb begin
      summary = 1'b0;
      for (int p = 0; p < NP; p++) begin
         summary = summary | (|flags_reg[p]);
      end
   end

   assign summary_flag_out = summary;

   // ==========================================================
   // control register, only the master enable bit is implemented
   // the other bits are forced to zero here so they always read back zero
   always_comb begin
      control_next = control_reg;
      if (wr_control) begin
         control_next = 8'h00;
         control_next[pin_change_pkg::CTRL_MASTER_EN_BIT] =
            wdata_in[pin_change_pkg::CTRL_MASTER_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         control_reg <= pin_change_pkg::CONTROL_RESET;
      end else begin
         control_reg <= control_next;
      end
   end

   // ==========================================================
   // per-port event status, sticky and cleared by writing one
   // any enabled edge detected on a port raises its event bit; set beats a same-cycle clear
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         evt_pulse[p] = |set_pulse[p];
      end
      evt_status_next = evt_status_reg;
      if (wr_evt_status) begin
         evt_status_next = evt_status_reg & ~wdata_in[NP-1:0];
      end
      evt_status_next = evt_status_next | evt_pulse;
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         evt_status_reg <= pin_change_pkg::EVT_STATUS_RESET[NP-1:0];
      end else begin
         evt_status_reg <= evt_status_next;
      end
   end

   // event mask register, same layout as the status
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         evt_mask_reg <= pin_change_pkg::EVT_MASK_RESET[NP-1:0];
      end else if (wr_evt_mask) begin
         evt_mask_reg <= wdata_in[NP-1:0];
      end
   end

   // ==========================================================
   // interrupt request: the master enable gates everything, so flags may
   // keep collecting while software polls with the request held off
   // the request follows the sticky event bits, not the flags, so software
   // must clear the event bit to drop irq_out; clearing only the flags leaves it set
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= master_en && (|(evt_status_next & evt_mask_reg));
      end
   end

   assign irq_out = irq_reg;

   // ==========================================================
   // wake from sleep: one-cycle pulse on a fresh edge while asleep
   // the event mask does not gate wake, only the master enable does
   // flags pending when sleep starts do not wake; only a fresh edge does,
   // so a stale flag cannot bounce the device straight back out of sleep
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= sleep_in && master_en && (|evt_pulse);
      end
   end

   assign wake_out = wake_reg;

   // ==========================================================
   // read mux; unmapped addresses and the bits above each field read zero
   // every register reads through one registered byte, so a read returns
   // the value that stood at the read edge, never a half-updated one
   always_comb begin
      rdata_next = pin_change_pkg::RDATA_RESET;
      if (rd_in) begin
         for (int p = 0; p < NP; p++) begin
            if (hit(addr_in, port_addr(p, pin_change_pkg::KIND_RISE))) begin
               rdata_next = rise_en_reg[p];
            end
            if (hit(addr_in, port_addr(p, pin_change_pkg::KIND_FALL))) begin
               rdata_next = fall_en_reg[p];
            end
            if (hit(addr_in, port_addr(p, pin_change_pkg::KIND_FLAGS))) begin
               rdata_next = flags_reg[p];
            end
         end
         case (addr_in)
            pin_change_pkg::OFF_CONTROL: begin
               rdata_next = control_reg;
            end
            pin_change_pkg::OFF_SUMMARY: begin
               rdata_next = '0;
               rdata_next[pin_change_pkg::SUMMARY_FLAG_BIT] = summary;
            end
            pin_change_pkg::OFF_EVT_STATUS: begin
               rdata_next = {{(8-NP){1'b0}}, evt_status_reg};
            end
            pin_change_pkg::OFF_EVT_MASK: begin
               rdata_next = {{(8-NP){1'b0}}, evt_mask_reg};
            end
            default: begin
               rdata_next = rdata_next;
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_reg <= pin_change_pkg::RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;

endmodule

// File: verif/pin_change_checker.sv
// checker for the pin change unit: read layout, summary, irq and wake timing
// assumes binding to pin_change_unit; edges reach the flags three cycles after the pins
`timescale 1ns/1ns
module pin_change_checker (
   input wire logic       clk_sys_in,
   input wire logic       nrst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [7:0] porta_pins_in,
   input wire logic [7:0] portb_pins_in,
   input wire logic [7:0] portc_pins_in,
   input wire logic       sleep_in,
   input wire logic       irq_out,
   input wire logic       summary_flag_out,
   input wire logic       wake_out
);
   // ======================================================
   // pin change history; a window of three cycles absorbs the synchroniser
   logic [23:0] pin_q;
   logic [5:0]  chg_q;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_q <= 24'h000000;
         chg_q <= 6'h00;
      end else begin
         pin_q <= {portc_pins_in, portb_pins_in, porta_pins_in};
         chg_q <= {chg_q[4:0], |(pin_q ^ {portc_pins_in, portb_pins_in, porta_pins_in})};
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // ======================================================
   // unimplemented bits and summary read back
   porta_rise_a: assert property ($past(rd_in) && $past(addr_in) == 4'h0
      |-> rdata_out[7:6] == 2'h0) else $error("port a rise bits 7-6 set");
   porta_fall_a: assert property ($past(rd_in) && $past(addr_in) == 4'h1
      |-> rdata_out[7:6] == 2'h0) else $error("port a fall bits 7-6 set");
   porta_flags_a: assert property ($past(rd_in) && $past(addr_in) == 4'h2
      |-> rdata_out[7:6] == 2'h0) else $error("port a flag bits 7-6 set");
   portb_low_a: assert property ($past(rd_in) && $past(addr_in) inside {[4'h3:4'h5]}
      |-> rdata_out[3:0] == 4'h0) else $error("port b low bits set");
   summary_read_a: assert property ($past(rd_in) && $past(addr_in) == 4'ha
      |-> rdata_out == {7'h00, $past(summary_flag_out)}) else $error("summary read wrong");
   // ======================================================
   // flags and requests move only for a pin change or a write
   summary_rise_a: assert property ($rose(summary_flag_out)
      |-> |chg_q[4:2] || $past(wr_in)) else $error("summary rose without cause");
   summary_fall_a: assert property ($fell(summary_flag_out)
      |-> $past(wr_in)) else $error("summary fell without write");
   irq_rise_a: assert property ($rose(irq_out)
      |-> |chg_q[4:2] || $past(wr_in) || $past(wr_in, 2)) else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq_out)
      |-> $past(wr_in) || $past(wr_in, 2)) else $error("irq fell without write");
   wake_sleep_a: assert property (wake_out |-> $past(sleep_in))
      else $error("wake while awake");
   wake_edge_a: assert property (wake_out |-> |chg_q[4:2])
      else $error("wake without edge");
endmodule

bind pin_change_unit pin_change_checker chk (.*);

// File: verif/pin_source.sv
// off-chip drivers of ports a, b and c
// assumes the bench asks for new levels no faster than the detector follows
`timescale 1ns/1ns
module pin_source (
   input  wire logic [2:0][7:0] level_in,
   input  wire logic            clk_sys_in,
   output logic      [7:0]      porta_out,
   output logic      [7:0]      portb_out,
   output logic      [7:0]      portc_out
);
   // start low so the synchroniser sees no phantom edge
   initial {portc_out, portb_out, porta_out} = 24'h000000;
   // levels move just after an edge and hold a whole cycle, so no pulse is missed
   always @(posedge clk_sys_in) begin
      porta_out <= level_in[0];
      portb_out <= level_in[1];
      portc_out <= level_in[2];
   end
endmodule

// File: verif/pin_change_unit_test.sv
// self-checking bench for the pin change unit against a behavioural model
// assumes pin_source drives the pins and the checker binds itself
`timescale 1ns/1ns
module pin_change_unit_test;
   logic            clk_sys_in = 1'b0;
   logic            nrst_in    = 1'b0;
   logic [3:0]      addr_in    = 4'h0;
   logic [7:0]      wdata_in   = 8'h00;
   logic            wr_in      = 1'b0;
   logic            rd_in      = 1'b0;
   logic            sleep_in   = 1'b0;
   logic [2:0][7:0] level      = 24'h000000;
   logic [7:0]      rdata_out, pa, pb, pc, r, c;
   logic            irq_out, summary_flag_out, wake_out, master_m;
   logic [7:0]      rise_m[3], fall_m[3], flag_m[3], cur_m[3];
   logic [2:0]      st_m, mask_m;
   int              err_count = 0, check_count = 0, wake_n = 0, wake_exp = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   pin_source src (.level_in(level), .clk_sys_in(clk_sys_in),
      .porta_out(pa), .portb_out(pb), .portc_out(pc));
   pin_change_unit dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .porta_pins_in(pa), .portb_pins_in(pb), .portc_pins_in(pc), .sleep_in(sleep_in),
      .irq_out(irq_out), .summary_flag_out(summary_flag_out), .wake_out(wake_out));
   // wake pulses are one cycle; counted mid-cycle, where the pulse has settled
   always @(negedge clk_sys_in) if (wake_out === 1'b1) wake_n++;
   // ======================================================
   // comparison, bus cycles and pin moves
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   // the model decides which bits flag before the pins move
   task automatic pins_to(input int p, input logic [7:0] v);
      logic [7:0] s;
      s = (rise_m[p] & v & ~cur_m[p] | fall_m[p] & ~v & cur_m[p]) & pin_change_pkg::PORT_IMPL[p];
      flag_m[p] |= s;
      if (s != 8'h00) st_m[p] = 1'b1;
      if (s != 8'h00 && sleep_in && master_m) wake_exp++;
      cur_m[p] = v;
      level[p] <= v;
      repeat (8) @(posedge clk_sys_in);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ======================================================
   // watchdog well beyond the fewer than two thousand cycles the sequence needs
   initial begin
      #(40 * 20000);
      err_count++;
      $display("Error %0t: timeout", $time);
      stop_test;
   end
   initial begin
      for (int p = 0; p < 3; p++) {rise_m[p], fall_m[p], flag_m[p], cur_m[p]} = 32'h0;
      st_m = 3'h0;
      master_m = 1'b0;
      void'($urandom(32'hcd5144eb));
      repeat (10) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      // reset values everywhere, unmapped write ignored
      bus_wr(4'hd, 8'hff);
      for (int a = 0; a < 16; a++) begin
         bus_rd(4'(a), r);
         chk(r, 8'h00);
      end
      // only implemented bits hold a written one
      for (int a = 0; a < 9; a++) begin
         bus_wr(4'(a), 8'hff);
         bus_rd(4'(a), r);
         chk(r, pin_change_pkg::PORT_IMPL[a / 3]);
         bus_wr(4'(a), 8'h00);
      end
      bus_wr(pin_change_pkg::OFF_EVT_STATUS, 8'hff);
      // random enables, master, mask and sleep against random pin moves
      for (int i = 0; i < 60; i++) begin
         int p;
         p = $urandom_range(2);
         master_m = 1'($urandom_range(1));
         mask_m = 3'($urandom);
         sleep_in <= 1'($urandom_range(1));
         r = 8'($urandom);
         bus_wr(4'(3 * p), r);
         rise_m[p] = r & pin_change_pkg::PORT_IMPL[p];
         r = 8'($urandom);
         bus_wr(4'(3 * p + 1), r);
         fall_m[p] = r & pin_change_pkg::PORT_IMPL[p];
         bus_wr(pin_change_pkg::OFF_CONTROL, {7'h00, master_m});
         bus_wr(pin_change_pkg::OFF_EVT_MASK, {5'h00, mask_m});
         pins_to(p, 8'($urandom));
         bus_rd(4'(3 * p + 2), r);
         chk(r, flag_m[p]);
         chk(8'(summary_flag_out), 8'(|(flag_m[0] | flag_m[1] | flag_m[2])));
         chk(8'(irq_out), 8'(master_m && (st_m & mask_m) != 3'h0));
         // clear a random subset of the bits seen, the and-mask way
         c = r & 8'($urandom);
         bus_wr(4'(3 * p + 2), r & ~c);
         flag_m[p] &= ~c;
         bus_rd(4'(3 * p + 2), r);
         chk(r, flag_m[p]);
         c = 8'($urandom);
         bus_wr(pin_change_pkg::OFF_EVT_STATUS, c);
         st_m &= ~c[2:0];
         bus_rd(pin_change_pkg::OFF_EVT_STATUS, r);
         chk(r, {5'h00, st_m});
         chk(8'(irq_out), 8'(master_m && (st_m & mask_m) != 3'h0));
      end
      chk(8'(wake_n), 8'(wake_exp));
      // an edge landing on the clearing write leaves the flag set
      bus_wr(4'h6, 8'h00);
      bus_wr(4'h7, 8'h00);
      {rise_m[2], fall_m[2]} = 16'h0000;
      pins_to(2, 8'h00);
      bus_wr(4'h6, 8'h01);
      bus_wr(4'h8, 8'h00);
      @(posedge clk_sys_in);
      level[2] <= 8'h01;
      // pins move after the next edge and the set pulse stands two edges later,
      // so the write raised at that edge is sampled with the pulse
      repeat (2) @(posedge clk_sys_in);
      bus_wr(4'h8, 8'h00);
      bus_rd(4'h8, r);
      chk(r, 8'h01);
      // the summary ignores writes
      bus_wr(pin_change_pkg::OFF_SUMMARY, 8'h00);
      bus_rd(pin_change_pkg::OFF_SUMMARY, r);
      chk(r, 8'h01);
      stop_test;
   end
endmodule
